// ### scr_cal_chk_assertions.sv
// Purpose: Port timing checks for the calibration register bank.
// Assumes: One clock, reset active high.
// Notes: Phase lengths are left to the bench; a_min checks only a minimum freq phase length.
`timescale 1ns/1ns
module scr_cal_chk (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Watched outputs
    input wire logic lock_detect_enable_o,
    input wire logic power_down_o,
    input wire logic device_reset_o,
    input wire logic ref_path_enable_o,
    input wire logic reference_doubler_o,
    input wire logic amplitude_override_o,
    input wire logic cap_bank_override_o,
    input wire logic freq_cal_active_o,
    input wire logic amp_cal_active_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////////////
    // Soft reset, reset values and power-down
    property p_rpls; device_reset_o |=> !device_reset_o; endproperty
    a_rpls: assert property (p_rpls) else $error("reset pulse too long");
    property p_rdef; device_reset_o |-> ##[1:2] lock_detect_enable_o && ref_path_enable_o
        && !power_down_o && !reference_doubler_o && !amplitude_override_o && !cap_bank_override_o;
    endproperty
    a_rdef: assert property (p_rdef) else $error("defaults not restored");
    property p_pdn; power_down_o |-> ##[0:2] !freq_cal_active_o && !amp_cal_active_o; endproperty
    a_pdn: assert property (p_pdn) else $error("calibration runs powered down");
    property p_rval; $fell(rst_i) |-> lock_detect_enable_o && ref_path_enable_o; endproperty
    a_rval: assert property (p_rval) else $error("enable reset values");
    ////////////////////////////////////////////////////////////////////////////////
    // Calibration phases
    property p_excl; !(freq_cal_active_o && amp_cal_active_o); endproperty
    a_excl: assert property (p_excl) else $error("both phases active");
    property p_cap; $rose(freq_cal_active_o) |-> !cap_bank_override_o; endproperty
    a_cap: assert property (p_cap) else $error("freq phase under override");
    property p_amp; $rose(amp_cal_active_o) |-> !amplitude_override_o; endproperty
    a_amp: assert property (p_amp) else $error("amp phase under override");
    // No reference edge, no tick: the phase cannot end
    property p_hold; freq_cal_active_o && !ref_path_enable_o && !device_reset_o
        ##1 !power_down_o && !device_reset_o |-> freq_cal_active_o; endproperty
    a_hold: assert property (p_hold) else $error("phase ended without ticks");
    property p_min; $rose(freq_cal_active_o) |=> freq_cal_active_o [*8]; endproperty
    a_min: assert property (p_min) else $error("freq phase too short");
    c_freq: cover property ($rose(freq_cal_active_o));
    c_amp: cover property ($rose(amp_cal_active_o));
    c_rst: cover property (device_reset_o);
endmodule
bind scr_synth_cal_regs scr_cal_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .lock_detect_enable_o(lock_detect_enable_o), .power_down_o(power_down_o),
    .device_reset_o(device_reset_o), .ref_path_enable_o(ref_path_enable_o),
    .reference_doubler_o(reference_doubler_o), .amplitude_override_o(amplitude_override_o),
    .cap_bank_override_o(cap_bank_override_o), .freq_cal_active_o(freq_cal_active_o),
    .amp_cal_active_o(amp_cal_active_o));

// ### scr_frame_if.sv
// Purpose: Carries decoded serial frames between the receiver and the register bank.
// Assumes: Both ends on clk_i.
// Notes: rd_data is combinational from the bank, sampled by the receiver.
`timescale 1ns/1ns
interface scr_frame_if;
    logic wr_stb;
    logic [6:0] wr_addr;
    logic [15:0] wr_data;
    logic [6:0] rd_addr;
    logic [15:0] rd_data;
    logic sdo;

    modport rx (
        output wr_stb,
        output wr_addr,
        output wr_data,
        output rd_addr,
        output sdo,
        input rd_data
    );

    modport regs (
        input wr_stb,
        input wr_addr,
        input wr_data,
        input rd_addr,
        input sdo,
        output rd_data
    );
endinterface

// ### scr_host_model.sv
// Purpose: Host side of the four-wire serial link.
// Assumes: SCK half period of 8 clk, SCK idle low.
// Notes: Readback taken at the SCK rise of each of the 16 data bits.
`timescale 1ns/1ns
module scr_host_model (
    // Clock and status pin
    input wire logic clk_i,
    input wire logic pin_i,
    // Serial pins
    output logic csb_o,
    output logic sck_o,
    output logic sdi_o
);
    initial begin
        csb_o = 1'b1;
        sck_o = 1'b0;
        sdi_o = 1'b0;
    end
    // Caller fills unnamed bits with map defaults
    task automatic xfer(input logic [23:0] f, output logic [15:0] rd);
        rd = 16'h0000;
        @(negedge clk_i);
        csb_o = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            sdi_o = f[i];
            repeat (8) @(negedge clk_i);
            sck_o = 1'b1;
            if (i < 16) begin
                rd[i] = pin_i;
            end
            repeat (8) @(negedge clk_i);
            sck_o = 1'b0;
        end
        repeat (4) @(negedge clk_i);
        csb_o = 1'b1;
        sdi_o = ~sdi_o; // Flip released data
        repeat (8) @(negedge clk_i); // Commit takes 4 clk
    endtask
endmodule

// ### scr_pkg.sv
// Purpose: Shared constants for the synthesizer calibration register bank.
// Assumes: 24-bit serial frame, read/write flag first, then 7-bit address, 16-bit data.
// Notes: Bits that have no function here store whatever the host writes.
package scr_pkg;

    // Frame layout
    localparam int unsigned SCR_FRAME_BITS = 24;
    localparam int unsigned SCR_ADDR_W = 7;
    localparam int unsigned SCR_DATA_W = 16;
    localparam int unsigned SCR_RW_POS = 23;
    localparam int unsigned SCR_HDR_BITS = 8;

    // Register addresses
    localparam logic [6:0] SCR_ADDR_MAIN = 7'h00;
    localparam logic [6:0] SCR_ADDR_CDIV = 7'h01;
    localparam logic [6:0] SCR_ADDR_RSV2 = 7'h02;
    localparam logic [6:0] SCR_ADDR_AMPD = 7'h04;
    localparam logic [6:0] SCR_ADDR_RSV7 = 7'h07;
    localparam logic [6:0] SCR_ADDR_OSC = 7'h08;
    localparam logic [6:0] SCR_ADDR_REFP = 7'h09;

    // Field positions in main_control
    localparam int unsigned SCR_LOCK_DETECT_ENABLE_POS = 13;
    localparam int unsigned SCR_HPFD_LSB = 7;
    localparam int unsigned SCR_LPFD_LSB = 5;
    localparam int unsigned SCR_AMPLITUDE_CAL_ENABLE_POS = 4;
    localparam int unsigned SCR_FREQUENCY_CAL_ENABLE_POS = 3;
    localparam int unsigned SCR_PIN_SEL_POS = 2;
    localparam int unsigned SCR_RESET_POS = 1;
    localparam int unsigned SCR_PDN_POS = 0;

    // Field positions in the other registers
    localparam int unsigned SCR_CDIV_LSB = 0;
    localparam int unsigned SCR_CMP_DLY_LSB = 8;
    localparam int unsigned SCR_AMP_OVR_POS = 13;
    localparam int unsigned SCR_CAP_OVR_POS = 10;
    localparam int unsigned SCR_DOUBLER_POS = 11;
    localparam int unsigned SCR_REF_EN_POS = 9;

    // Reset values
    localparam logic [15:0] SCR_MAIN_RST = 16'h201c;
    localparam logic [15:0] SCR_CDIV_RST = 16'h0000;
    localparam logic [15:0] SCR_RSV2_RST = 16'h0000;
    localparam logic [15:0] SCR_AMPD_RST = 16'h1900;
    localparam logic [15:0] SCR_RSV7_RST = 16'h0000;
    localparam logic [15:0] SCR_OSC_RST = 16'h0000;
    localparam logic [15:0] SCR_REFP_RST = 16'h0200;

    // Frequency calibration length in calibration clock ticks
    localparam logic [8:0] SCR_FCAL_BASE_TICKS = 9'h010;
    localparam int unsigned SCR_FCAL_ADJ_SHIFT = 2;

    // Calibration sequencer states
    typedef enum logic [2:0] {
        SCR_CAL_IDLE = 3'b001,
        SCR_CAL_FREQ = 3'b010,
        SCR_CAL_AMP = 3'b100
    } scr_cal_state_t;

endpackage

// ### scr_serial_rx.sv
// Purpose: Four-wire serial receiver: shifts frames in and readback data out.
// Assumes: Serial clock at most about a tenth of clk_i, pins asynchronous.
// Notes: A write is committed only at chip-select release after exactly 24 bits.
`timescale 1ns/1ns
module scr_serial_rx
    import scr_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Serial pins
    input wire logic csb_i,
    input wire logic sck_i,
    input wire logic sdi_i,
    // Frame carrier
    scr_frame_if.rx fr
);
    import scr_pkg::*;

    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic [2:0] prev_reg;
    logic [23:0] shift_reg, shift_next;
    logic [4:0] cnt_reg, cnt_next;
    logic [15:0] rd_shift_reg, rd_shift_next;
    logic load_reg, load_next;
    logic sdo_reg, sdo_next;
    logic wr_stb_reg, wr_stb_next;
    logic [6:0] wr_addr_reg, wr_addr_next;
    logic [15:0] wr_data_reg, wr_data_next;
    logic csb_s, sck_rise, sck_fall, csb_rise;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; logic reads stage two
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1_reg <= 3'h7;
            sync2_reg <= 3'h7;
            prev_reg <= 3'h7;
        end else begin
            sync1_reg <= {csb_i, sck_i, sdi_i};
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    assign csb_s = sync2_reg[2];
    assign sck_rise = sync2_reg[1] & ~prev_reg[1] & ~csb_s;
    assign sck_fall = ~sync2_reg[1] & prev_reg[1] & ~csb_s;
    assign csb_rise = sync2_reg[2] & ~prev_reg[2];

    ////////////////////////////////////////////////////////////////////////
    // Shift, count and readback next state
    always_comb begin
        shift_next = shift_reg;
        cnt_next = cnt_reg;
        rd_shift_next = rd_shift_reg;
        load_next = 1'b0;
        sdo_next = sdo_reg;
        wr_stb_next = 1'b0;
        wr_addr_next = wr_addr_reg;
        wr_data_next = wr_data_reg;
        if (csb_s) begin
            cnt_next = 5'h00;
            sdo_next = 1'b0;
        end else if (sck_rise) begin
            shift_next = {shift_reg[22:0], sync2_reg[0]};
            // Saturate: long frames are refused
            if (cnt_reg != 5'h1f) begin
                cnt_next = cnt_reg + 5'h01;
            end
            load_next = (cnt_reg == 5'(SCR_HDR_BITS - 1));
        end else if (sck_fall && cnt_reg >= 5'(SCR_HDR_BITS)) begin
            // Changes on SCK fall in any frame; host samples on the rise
            sdo_next = rd_shift_reg[15];
            rd_shift_next = {rd_shift_reg[14:0], 1'b0};
        end
        if (load_reg) begin
            rd_shift_next = fr.rd_data;
        end
        if (csb_rise && cnt_reg == 5'(SCR_FRAME_BITS) && !shift_reg[SCR_RW_POS]) begin
            wr_stb_next = 1'b1;
            wr_addr_next = shift_reg[22:16];
            wr_data_next = shift_reg[15:0];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            shift_reg <= 24'h000000;
            cnt_reg <= 5'h00;
            rd_shift_reg <= 16'h0000;
            load_reg <= 1'b0;
            sdo_reg <= 1'b0;
            wr_stb_reg <= 1'b0;
            wr_addr_reg <= 7'h00;
            wr_data_reg <= 16'h0000;
        end else begin
            shift_reg <= shift_next;
            cnt_reg <= cnt_next;
            rd_shift_reg <= rd_shift_next;
            load_reg <= load_next;
            sdo_reg <= sdo_next;
            wr_stb_reg <= wr_stb_next;
            wr_addr_reg <= wr_addr_next;
            wr_data_reg <= wr_data_next;
        end
    end

    // Carrier outputs
    assign fr.wr_stb = wr_stb_reg;
    assign fr.wr_addr = wr_addr_reg;
    assign fr.wr_data = wr_data_reg;
    assign fr.rd_addr = shift_reg[6:0];
    assign fr.sdo = sdo_reg;
endmodule

// ### scr_synth_cal_regs.sv
// Purpose: Calibration and control register bank of a wideband synthesizer.
// Assumes: Reference input well below clk_i/2 so its edges can be sampled.
// Notes: Calibration timing is modelled by counting divided reference ticks.
`timescale 1ns/1ns
module scr_synth_cal_regs
    import scr_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Serial programming pins
    input wire logic csb_i,
    input wire logic sck_i,
    input wire logic sdi_i,
    // Analog-side inputs
    input wire logic reference_input_i,
    input wire logic pll_locked_i,
    // Status pin
    output logic multiplexed_status_pin_o,
    // Control outputs
    output logic lock_detect_enable_o,
    output logic power_down_o,
    output logic device_reset_o,
    output logic ref_path_enable_o,
    output logic reference_doubler_o,
    output logic amplitude_override_o,
    output logic cap_bank_override_o,
    output logic freq_cal_active_o,
    output logic amp_cal_active_o
);
    import scr_pkg::*;

    scr_frame_if fr ();

    scr_serial_rx u_rx (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .csb_i(csb_i),
        .sck_i(sck_i),
        .sdi_i(sdi_i),
        .fr(fr)
    );

    logic [15:0] main_reg, main_next;
    logic [15:0] cdiv_reg, cdiv_next;
    logic [15:0] rsv2_reg, rsv2_next;
    logic [15:0] ampd_reg, ampd_next;
    logic [15:0] rsv7_reg, rsv7_next;
    logic [15:0] osc_reg, osc_next;
    logic [15:0] refp_reg, refp_next;
    logic soft_rst_reg, soft_rst_next;
    logic cal_start;

    // Readback multiplexer; unmapped addresses read as zero
    function automatic logic [15:0] scr_read(input logic [6:0] a,
                                             input logic [15:0] r0, input logic [15:0] r1,
                                             input logic [15:0] r2, input logic [15:0] r4,
                                             input logic [15:0] r7, input logic [15:0] r8,
                                             input logic [15:0] r9);
        logic [15:0] v;
        v = 16'h0000;
        unique case (a)
            SCR_ADDR_MAIN: v = r0;
            SCR_ADDR_CDIV: v = r1;
            SCR_ADDR_RSV2: v = r2;
            SCR_ADDR_AMPD: v = r4;
            SCR_ADDR_RSV7: v = r7;
            SCR_ADDR_OSC: v = r8;
            SCR_ADDR_REFP: v = r9;
            default: v = 16'h0000;
        endcase
        return v;
    endfunction

    assign fr.rd_data = scr_read(fr.rd_addr, main_reg, cdiv_reg, rsv2_reg,
                                 ampd_reg, rsv7_reg, osc_reg, refp_reg);

    ////////////////////////////////////////////////////////////////////////
    // Register file next state
    always_comb begin
        main_next = main_reg;
        cdiv_next = cdiv_reg;
        rsv2_next = rsv2_reg;
        ampd_next = ampd_reg;
        rsv7_next = rsv7_reg;
        osc_next = osc_reg;
        refp_next = refp_reg;
        soft_rst_next = 1'b0;
        if (soft_rst_reg) begin
            // A frame in the reset cycle is dropped
            main_next = SCR_MAIN_RST;
            cdiv_next = SCR_CDIV_RST;
            rsv2_next = SCR_RSV2_RST;
            ampd_next = SCR_AMPD_RST;
            rsv7_next = SCR_RSV7_RST;
            osc_next = SCR_OSC_RST;
            refp_next = SCR_REFP_RST;
        end else if (fr.wr_stb) begin
            unique case (fr.wr_addr)
                SCR_ADDR_MAIN: begin
                    main_next = fr.wr_data;
                    main_next[SCR_RESET_POS] = 1'b0;
                    soft_rst_next = fr.wr_data[SCR_RESET_POS];
                end
                SCR_ADDR_CDIV: cdiv_next = fr.wr_data;
                SCR_ADDR_RSV2: rsv2_next = fr.wr_data;
                SCR_ADDR_AMPD: ampd_next = fr.wr_data;
                SCR_ADDR_RSV7: rsv7_next = fr.wr_data;
                SCR_ADDR_OSC: osc_next = fr.wr_data;
                SCR_ADDR_REFP: refp_next = fr.wr_data;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            main_reg <= SCR_MAIN_RST;
            cdiv_reg <= SCR_CDIV_RST;
            rsv2_reg <= SCR_RSV2_RST;
            ampd_reg <= SCR_AMPD_RST;
            rsv7_reg <= SCR_RSV7_RST;
            osc_reg <= SCR_OSC_RST;
            refp_reg <= SCR_REFP_RST;
            soft_rst_reg <= 1'b0;
        end else begin
            main_reg <= main_next;
            cdiv_reg <= cdiv_next;
            rsv2_reg <= rsv2_next;
            ampd_reg <= ampd_next;
            rsv7_reg <= rsv7_next;
            osc_reg <= osc_next;
            refp_reg <= refp_next;
            soft_rst_reg <= soft_rst_next;
        end
    end

    // Start on a written one, never with a reset or power-down
    assign cal_start = fr.wr_stb && fr.wr_addr == SCR_ADDR_MAIN &&
                       fr.wr_data[SCR_FREQUENCY_CAL_ENABLE_POS] && !fr.wr_data[SCR_RESET_POS] &&
                       !fr.wr_data[SCR_PDN_POS] && !soft_rst_reg;

    ////////////////////////////////////////////////////////////////////////
    // Calibration clock: divided reference edges become one-cycle ticks
    logic ref1_reg, ref2_reg, ref3_reg;
    logic [6:0] div_cnt_reg, div_cnt_next;
    logic tick_reg, tick_next;
    logic ref_edge;
    logic [7:0] div_mask;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ref1_reg <= 1'b0;
            ref2_reg <= 1'b0;
            ref3_reg <= 1'b0;
        end else begin
            ref1_reg <= reference_input_i;
            ref2_reg <= ref1_reg;
            ref3_reg <= ref2_reg;
        end
    end

    // Divider counts rising pin edges; the doubler bit does not change the ticks
    assign ref_edge = refp_reg[SCR_REF_EN_POS] && ref2_reg && !ref3_reg;
    assign div_mask = (8'h01 << cdiv_reg[SCR_CDIV_LSB +: 3]) - 8'h01;

    always_comb begin
        div_cnt_next = div_cnt_reg;
        tick_next = 1'b0;
        if (ref_edge) begin
            if (div_cnt_reg >= div_mask[6:0]) begin
                div_cnt_next = 7'h00;
                tick_next = 1'b1;
            end else begin
                div_cnt_next = div_cnt_reg + 7'h01;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_cnt_reg <= 7'h00;
            tick_reg <= 1'b0;
        end else begin
            div_cnt_reg <= div_cnt_next;
            tick_reg <= tick_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Calibration sequencer: frequency phase, then amplitude phase
    scr_cal_state_t cal_state_reg, cal_state_next;
    logic [8:0] timer_reg, timer_next;
    logic freq_run, amp_run;
    logic [8:0] freq_len;
    logic [2:0] adj_sum;

    assign freq_run = main_reg[SCR_FREQUENCY_CAL_ENABLE_POS] && !osc_reg[SCR_CAP_OVR_POS];
    assign amp_run = main_reg[SCR_AMPLITUDE_CAL_ENABLE_POS] && !osc_reg[SCR_AMP_OVR_POS];
    // Adjusts taken from the starting write
    assign adj_sum = {1'b0, fr.wr_data[SCR_HPFD_LSB +: 2]} +
                     {1'b0, fr.wr_data[SCR_LPFD_LSB +: 2]};
    assign freq_len = SCR_FCAL_BASE_TICKS + 9'({adj_sum, 2'b00});

    always_comb begin
        cal_state_next = cal_state_reg;
        timer_next = timer_reg;
        if (main_reg[SCR_PDN_POS] || soft_rst_reg) begin
            cal_state_next = SCR_CAL_IDLE;
            timer_next = 9'h000;
        end else begin
            unique case (cal_state_reg)
                SCR_CAL_IDLE: begin
                    if (cal_start) begin
                        // Overrides as stored before this write
                        if (!osc_reg[SCR_CAP_OVR_POS]) begin
                            cal_state_next = SCR_CAL_FREQ;
                            timer_next = freq_len;
                        end else if (amp_run) begin
                            cal_state_next = SCR_CAL_AMP;
                            timer_next = {1'b0, ampd_reg[SCR_CMP_DLY_LSB +: 8]};
                        end
                    end
                end
                SCR_CAL_FREQ: begin
                    if (!freq_run) begin
                        cal_state_next = SCR_CAL_IDLE;
                    end else if (timer_reg == 9'h000) begin
                        if (amp_run) begin
                            cal_state_next = SCR_CAL_AMP;
                            timer_next = {1'b0, ampd_reg[SCR_CMP_DLY_LSB +: 8]};
                        end else begin
                            cal_state_next = SCR_CAL_IDLE;
                        end
                    end else if (tick_reg) begin
                        timer_next = timer_reg - 9'h001;
                    end
                end
                SCR_CAL_AMP: begin
                    if (!amp_run || timer_reg == 9'h000) begin
                        cal_state_next = SCR_CAL_IDLE;
                    end else if (tick_reg) begin
                        timer_next = timer_reg - 9'h001;
                    end
                end
                default: begin
                    cal_state_next = SCR_CAL_IDLE;
                    timer_next = 9'h000;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cal_state_reg <= SCR_CAL_IDLE;
            timer_reg <= 9'h000;
        end else begin
            cal_state_reg <= cal_state_next;
            timer_reg <= timer_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status pin: lock status or readback, registered
    logic lock1_reg, lock2_reg;
    logic pin_reg, pin_next;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            lock1_reg <= 1'b0;
            lock2_reg <= 1'b0;
        end else begin
            lock1_reg <= pll_locked_i;
            lock2_reg <= lock1_reg;
        end
    end

    // Lock reads low while calibrating, down or disabled
    always_comb begin
        if (main_reg[SCR_PIN_SEL_POS]) begin
            pin_next = main_reg[SCR_LOCK_DETECT_ENABLE_POS] && lock2_reg && !main_reg[SCR_PDN_POS] &&
                       cal_state_reg == SCR_CAL_IDLE;
        end else begin
            pin_next = fr.sdo;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_reg <= 1'b0;
        end else begin
            pin_reg <= pin_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from flip-flops
    assign multiplexed_status_pin_o = pin_reg;
    assign lock_detect_enable_o = main_reg[SCR_LOCK_DETECT_ENABLE_POS];
    assign power_down_o = main_reg[SCR_PDN_POS];
    assign device_reset_o = soft_rst_reg;
    assign ref_path_enable_o = refp_reg[SCR_REF_EN_POS];
    assign reference_doubler_o = refp_reg[SCR_DOUBLER_POS];
    assign amplitude_override_o = osc_reg[SCR_AMP_OVR_POS];
    assign cap_bank_override_o = osc_reg[SCR_CAP_OVR_POS];
    assign freq_cal_active_o = cal_state_reg[1];
    assign amp_cal_active_o = cal_state_reg[2];
endmodule

// ### scr_synth_cal_regs_bench.sv
// Purpose: Self-checking bench for the calibration register bank.
// Assumes: Reference of 8 clk period, inputs driven on falling edges.
// Notes: Phase lengths judged within a tick plus write latency.
`timescale 1ns/1ns
module scr_synth_cal_regs_bench;
    import scr_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic rf = 1'b0;
    logic lk = 1'b0;
    logic csb, sck, sdi, pin, ld, pdn, drst, ren, dbl, aov, cov, fa, aa;
    logic [15:0] rd;
    int err_count = 0;
    int n_tests = 0;
    int nrst = 0;
    always #5 clk_i = ~clk_i;
    // Reference far below 50MHz
    always #40 rf = ~rf;
    always @(posedge clk_i) if (drst) nrst <= nrst + 1;
    scr_synth_cal_regs u_dut (.clk_i(clk_i), .rst_i(rst_i), .csb_i(csb), .sck_i(sck),
        .sdi_i(sdi), .reference_input_i(rf), .pll_locked_i(lk), .multiplexed_status_pin_o(pin),
        .lock_detect_enable_o(ld), .power_down_o(pdn), .device_reset_o(drst),
        .ref_path_enable_o(ren), .reference_doubler_o(dbl), .amplitude_override_o(aov),
        .cap_bank_override_o(cov), .freq_cal_active_o(fa), .amp_cal_active_o(aa));
    scr_host_model u_host (.clk_i(clk_i), .pin_i(pin), .csb_o(csb), .sck_o(sck), .sdi_o(sdi));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        u_host.xfer({1'b0, a, d}, rd);
    endtask
    task automatic rdc(input string nm, input logic [6:0] a, input logic [15:0] exp);
        u_host.xfer({1'b1, a, 16'h0000}, rd);
        check(nm, rd, exp);
    endtask
    // Counts phase cycles until idle
    task automatic meas(output int nf, output int na);
        nf = 0;
        na = 0;
        for (int c = 0; c < 3000 && (c < 4 || fa === 1'b1 || aa === 1'b1); c++) begin
            @(negedge clk_i);
            nf += int'(fa);
            na += int'(aa);
        end
    endtask
    function automatic logic [15:0] near(int n, int e, int p);
        return 16'(n >= e - p - 12 && n <= e + p);
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_dflt();
        lk = 1'b1;
        repeat (6) @(negedge clk_i);
        check("ld", ld, 1'b1);
        check("ren", ren, 1'b1);
        check("pdn", pdn, 1'b0);
        check("dbl", dbl, 1'b0);
        check("pin_lock", pin, 1'b1);
        lk = 1'b0;
        repeat (6) @(negedge clk_i);
        check("pin_unlock", pin, 1'b0);
        wr(SCR_ADDR_MAIN, 16'h2010);
        rdc("main", SCR_ADDR_MAIN, 16'h2010);
        rdc("cdiv", SCR_ADDR_CDIV, SCR_CDIV_RST);
        rdc("rsv2", SCR_ADDR_RSV2, SCR_RSV2_RST);
        rdc("ampd", SCR_ADDR_AMPD, 16'h1900);
        rdc("rsv7", SCR_ADDR_RSV7, SCR_RSV7_RST);
        rdc("osc", SCR_ADDR_OSC, 16'h0000);
        rdc("refp", SCR_ADDR_REFP, 16'h0200);
        wr(7'h03, 16'h5a5a);
        rdc("unmapped", 7'h03, 16'h0000);
        $display("t_dflt done");
    endtask
    task automatic t_ovr();
        wr(SCR_ADDR_OSC, 16'h2400); // Core kept as chosen
        wr(SCR_ADDR_REFP, 16'h0800);
        wr(SCR_ADDR_MAIN, 16'h0011);
        check("aov", aov, 1'b1);
        check("cov", cov, 1'b1);
        check("dbl_on", dbl, 1'b1);
        check("ren_off", ren, 1'b0);
        check("pdn_on", pdn, 1'b1);
        check("ld_off", ld, 1'b0);
        rdc("osc_rb", SCR_ADDR_OSC, 16'h2400);
        wr(SCR_ADDR_MAIN, 16'h0013);
        check("one_pulse", 16'(nrst), 16'h0001);
        check("def", {ld, ren, pdn, dbl, aov, cov}, 16'h0030);
        $display("t_ovr done");
    endtask
    task automatic t_cal();
        int hp[4] = '{0, 1, 2, 3};
        int lp[4] = '{0, 2, 1, 3};
        int dv[4] = '{0, 0, 1, 0};
        int db[4] = '{0, 0, 0, 1};
        int p, nf, na;
        wr(SCR_ADDR_AMPD, 16'h0a00); // 2 x 10 x 80ns > 200ns
        for (int k = 0; k < 4; k++) begin
            p = 8 << dv[k];
            wr(SCR_ADDR_CDIV, 16'(dv[k]));
            wr(SCR_ADDR_REFP, 16'h0200 | 16'(db[k] << 11));
            wr(SCR_ADDR_MAIN, 16'h201c | 16'(hp[k] << 7) | 16'(lp[k] << 5));
            meas(nf, na);
            check("flen", near(nf, (16 + 4 * (hp[k] + lp[k])) * p, p), 16'h0001);
            check("alen", near(na, 10 * p, p), 16'h0001);
        end
        wr(SCR_ADDR_CDIV, 16'h0000);
        wr(SCR_ADDR_REFP, 16'h0200);
        wr(SCR_ADDR_OSC, 16'h0400);
        wr(SCR_ADDR_MAIN, 16'h201c);
        meas(nf, na);
        check("cap_skip", 16'(nf), 16'h0000);
        check("amp_run", near(na, 80, 8), 16'h0001);
        wr(SCR_ADDR_OSC, 16'h2000);
        wr(SCR_ADDR_MAIN, 16'h201c);
        meas(nf, na);
        check("amp_skip", 16'(na), 16'h0000);
        wr(SCR_ADDR_OSC, 16'h0000);
        wr(SCR_ADDR_MAIN, 16'h200c);
        meas(nf, na);
        check("acal_off", 16'(na), 16'h0000);
        check("fcal_run", near(nf, 128, 8), 16'h0001);
        wr(SCR_ADDR_REFP, 16'h0000);
        wr(SCR_ADDR_MAIN, 16'h201c);
        repeat (200) @(negedge clk_i);
        check("no_ref_hold", fa, 1'b1);
        wr(SCR_ADDR_MAIN, 16'h201d);
        check("pdn_abort", {fa, aa}, 16'h0000);
        $display("t_cal done");
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Run is near 18k cycles
    initial begin
        repeat (60000) @(posedge clk_i);
        err_count++;
        results();
    end
    initial begin
        repeat (2) @(negedge clk_i);
        rst_i = 1'b0;
        t_dflt();
        t_ovr();
        t_cal();
        results();
    end
endmodule
